// file: include/sspc_pkg.sv
// Package: register map, field positions, reset values and timing constants for the sync/PLL control block
package sspc_pkg;
  // Register byte addresses (indices times four, printed offsets not all word aligned)
  localparam logic [7:0] idx_div_high  = 8'h01;
  localparam logic [7:0] idx_div_low   = 8'h02;
  localparam logic [7:0] idx_vco_pump  = 8'h03;
  localparam logic [7:0] idx_override  = 8'h0e;
  localparam logic [7:0] idx_status    = 8'h14;
  localparam logic [7:0] idx_sep_ticks = 8'h20;
  localparam logic [9:0] addr_div_high  = {idx_div_high, 2'b00};
  localparam logic [9:0] addr_div_low   = {idx_div_low, 2'b00};
  localparam logic [9:0] addr_vco_pump  = {idx_vco_pump, 2'b00};
  localparam logic [9:0] addr_override  = {idx_override, 2'b00};
  localparam logic [9:0] addr_status    = {idx_status, 2'b00};
  localparam logic [9:0] addr_sep_ticks = {idx_sep_ticks, 2'b00};
  // Field positions
  localparam int bit_hs_active   = 7;
  localparam int bit_hs_polarity = 5;
  localparam int bit_vs_active   = 4;
  localparam int bit_vs_polarity = 2;
  localparam int bit_sog_active  = 1;
  localparam int bit_ref_ovr     = 4;
  localparam int bit_ref_sel     = 3;
  localparam int bit_vs_ovr      = 1;
  localparam int bit_vs_sel      = 0;
  localparam int bit_comp_src    = 2;
  localparam int bit_coast_src   = 5;
  // Reset values
  localparam logic [11:0] rst_divider   = 12'h069d;
  localparam logic [7:0]  rst_vco_pump  = 8'h00;
  localparam logic [7:0]  rst_override  = 8'h00;
  localparam logic [7:0]  rst_sep_ticks = 8'h20;
  // Timing
  localparam int clk_hz           = 10_000_000;
  localparam int tick_hz          = 5_000_000;
  localparam int tick_div         = clk_hz / tick_hz;
  localparam int sync_settle      = 3;
  localparam int activity_time_us = 100;
  localparam int activity_cycles  = activity_time_us * (clk_hz / 1_000_000);
  localparam int vs_activity_ms   = 100;
  localparam int vs_activity_cycles = vs_activity_ms * (clk_hz / 1_000);
endpackage

// file: logic/sspc_sync_pll_ctrl.sv
// Sync detection, source selection, sync separator and PLL control registers with AXI4-Lite slave
// Operation
// - Horizontal sync activity shown in status bit 7, one means active.
// - PLL reference picks green sync, horizontal, or override bit 3 per table.
// - Horizontal polarity: mostly low is positive, reported in status bit 5.
// - Horizontal sync is polarity-corrected before feeding the PLL reference.
// - Composite mux feeds separator from green sync or horizontal input.
// - Separator rejects composite changes shorter than programmable ticks, default 32.
// - Separator ticks run on an internal 5 MHz timebase.
// - Vertical sync activity shown in status bit 4.
// - Vertical polarity from vertical output duty, reported in status bit 2.
// - Vertical source picks vertical input, separator, or override bit 0 per table.
// - Coast may be driven by vertical input or separator output.
// - Twelve-bit divider from two registers divides by setting plus one.
// - Effective divider equals pixel periods per line.
// - Divider resets to 1693, division 1694.
// - Register three top bits select the VCO range.
// - Register three bits 5:3 select charge pump current.
// - Pixel clock reference is locked to the selected horizontal sync.
// - Green sync slicer activity shown in status bit 1.
`timescale 1ns/1ps
module sspc_sync_pll_ctrl (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [9:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [9:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        hsync_in,
  input  wire logic        vsync_in,
  input  wire logic        green_sync_in,
  output logic             pll_ref_out,
  output logic             pll_ref_selector,
  output logic             vert_sync_out,
  output logic             vert_source_selector,
  output logic             coast_out,
  output logic             sep_vsync_out,
  output logic [11:0]      pll_divide_by,
  output logic [1:0]       vco_range,
  output logic [2:0]       pump_current
);
  localparam int act_w  = 24;
  localparam logic [act_w-1:0] act_lim    = act_w'(sspc_pkg::activity_cycles);
  localparam logic [act_w-1:0] vs_act_lim = act_w'(sspc_pkg::vs_activity_cycles);
  localparam logic [1:0] resp_okay   = 2'b00;
  localparam logic [1:0] resp_slverr = 2'b10;

  // Two-flop synchronisers, then one more stage for edge detection
  logic [2:0] hs_sync;
  logic [2:0] vs_sync;
  logic [2:0] gs_sync;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hs_sync <= 3'h0;
      vs_sync <= 3'h0;
      gs_sync <= 3'h0;
    end else begin
      hs_sync <= {hs_sync[1:0], hsync_in};
      vs_sync <= {vs_sync[1:0], vsync_in};
      gs_sync <= {gs_sync[1:0], green_sync_in};
    end
  end
  wire logic hs   = hs_sync[1];
  wire logic vs   = vs_sync[1];
  wire logic gs   = gs_sync[1];
  // Edges count only once the synchroniser holds real pin levels,
  // else a pin resting high would look like an edge right after reset
  logic [1:0] warm;
  logic       primed;
  assign primed = warm == 2'(sspc_pkg::sync_settle);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      warm <= 2'h0;
    end else if (!primed) begin
      warm <= warm + 2'h1;
    end
  end
  wire logic hs_e = primed && (hs_sync[1] ^ hs_sync[2]);
  wire logic vs_e = primed && (vs_sync[1] ^ vs_sync[2]);
  wire logic gs_e = primed && (gs_sync[1] ^ gs_sync[2]);

  // Registers
  logic [11:0] divider;
  logic [7:0]  vco_pump;
  logic [7:0]  override;
  logic [7:0]  sep_ticks;

  // Activity detectors: active while an edge was seen within the window
  // Limitation: a pin that goes quiet still reads active until the window runs out
  logic [act_w-1:0] hs_idle;
  logic [act_w-1:0] vs_idle;
  logic [act_w-1:0] gs_idle;
  logic             hs_active;
  logic             vs_active;
  logic             gs_active;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hs_idle   <= '0;
      hs_active <= 1'b0;
    end else if (hs_e) begin
      hs_idle   <= '0;
      hs_active <= 1'b1;
    end else if (hs_idle >= act_lim) begin
      hs_active <= 1'b0;
    end else begin
      hs_idle <= hs_idle + 1'b1;
    end
  end
  // Vertical window is long since frames are tens of milliseconds apart
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vs_idle   <= '0;
      vs_active <= 1'b0;
    end else if (vs_e) begin
      vs_idle   <= '0;
      vs_active <= 1'b1;
    end else if (vs_idle >= vs_act_lim) begin
      vs_active <= 1'b0;
    end else begin
      vs_idle <= vs_idle + 1'b1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gs_idle   <= '0;
      gs_active <= 1'b0;
    end else if (gs_e) begin
      gs_idle   <= '0;
      gs_active <= 1'b1;
    end else if (gs_idle >= act_lim) begin
      gs_active <= 1'b0;
    end else begin
      gs_idle <= gs_idle + 1'b1;
    end
  end

  // Duty-cycle polarity: up/down counter saturating, sign gives majority level
  // Saturation bounds how long an old majority takes to unwind after a swap
  logic signed [15:0] hs_duty;
  logic signed [15:0] vs_duty;
  logic               hs_pol;
  logic               vs_pol;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hs_duty <= 16'sh0000;
    end else if (hs && hs_duty != 16'sh7fff) begin
      hs_duty <= hs_duty + 16'sh0001;
    end else if (!hs && hs_duty != -16'sh7fff) begin
      hs_duty <= hs_duty - 16'sh0001;
    end
  end
  // Mostly low means positive
  assign hs_pol = hs_duty < 16'sh0000;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vs_duty <= 16'sh0000;
    end else if (vert_sync_out && vs_duty != 16'sh7fff) begin
      vs_duty <= vs_duty + 16'sh0001;
    end else if (!vert_sync_out && vs_duty != -16'sh7fff) begin
      vs_duty <= vs_duty - 16'sh0001;
    end
  end
  assign vs_pol = vs_duty < 16'sh0000;

  // Composite source mux and separator on a 5 MHz tick
  logic       comp_sync;
  logic [1:0] tick_cnt;
  logic       tick;
  logic [7:0] run_cnt;
  logic       sep_state;
  assign comp_sync = override[sspc_pkg::bit_comp_src] ? gs : hs;
  // Two bus clocks per tick
  assign tick = tick_cnt == 2'(sspc_pkg::tick_div - 1);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt <= 2'h0;
    end else if (tick) begin
      tick_cnt <= 2'h0;
    end else begin
      tick_cnt <= tick_cnt + 2'h1;
    end
  end
  // A change must persist for sep_ticks ticks before the output follows it
  // Trade-off: any break restarts the count, so a glitch inside a long pulse delays it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_cnt   <= 8'h00;
      sep_state <= 1'b0;
    end else if (comp_sync == sep_state) begin
      run_cnt <= 8'h00;
    end else if (run_cnt >= sep_ticks) begin
      sep_state <= comp_sync;
      run_cnt   <= 8'h00;
    end else if (tick) begin
      run_cnt <= run_cnt + 8'h01;
    end
  end

  // Selectors and outputs, all registered
  logic next_ref_sel;
  logic next_vs_sel;
  always_comb begin
    if (override[sspc_pkg::bit_ref_ovr]) begin
      next_ref_sel = override[sspc_pkg::bit_ref_sel];
    end else if (!hs_active && gs_active) begin
      next_ref_sel = 1'b1;
    end else if (hs_active && gs_active) begin
      next_ref_sel = override[sspc_pkg::bit_ref_sel];
    end else begin
      next_ref_sel = 1'b0;
    end
    if (override[sspc_pkg::bit_vs_ovr]) begin
      next_vs_sel = override[sspc_pkg::bit_vs_sel];
    end else if (vs_active) begin
      next_vs_sel = 1'b0;
    end else if (gs_active) begin
      next_vs_sel = 1'b1;
    end else begin
      next_vs_sel = override[sspc_pkg::bit_vs_sel];
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pll_ref_selector     <= 1'b0;
      vert_source_selector <= 1'b0;
      pll_ref_out          <= 1'b0;
      vert_sync_out        <= 1'b0;
      coast_out            <= 1'b0;
      sep_vsync_out        <= 1'b0;
    end else begin
      pll_ref_selector     <= next_ref_sel;
      vert_source_selector <= next_vs_sel;
      // Inverted when mostly high so the PLL always sees high-going pulses
      pll_ref_out   <= next_ref_sel ? ~gs : (hs ^ ~hs_pol);
      vert_sync_out <= next_vs_sel ? sep_state : vs;
      coast_out     <= override[sspc_pkg::bit_coast_src] ? sep_state : vs;
      sep_vsync_out <= sep_state;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pll_divide_by <= sspc_pkg::rst_divider;
      vco_range     <= sspc_pkg::rst_vco_pump[7:6];
      pump_current  <= sspc_pkg::rst_vco_pump[5:3];
    end else begin
      // Effective division is setting plus one, pixel periods per line
      pll_divide_by <= divider;
      vco_range     <= vco_pump[7:6];
      pump_current  <= vco_pump[5:3];
    end
  end

  // AXI4-Lite write: address and data taken in either order
  // A new address may be taken while bvalid waits; it is applied after the response
  logic [9:0]  aw_addr;
  logic        aw_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        w_held;
  logic        do_write;
  logic        wr_hit;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign wr_hit = aw_addr == sspc_pkg::addr_div_high || aw_addr == sspc_pkg::addr_div_low ||
                  aw_addr == sspc_pkg::addr_vco_pump || aw_addr == sspc_pkg::addr_override ||
                  aw_addr == sspc_pkg::addr_sep_ticks || aw_addr == sspc_pkg::addr_status;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 10'h000;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= resp_okay;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? resp_okay : resp_slverr;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // Status offset accepted but writes discarded
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      divider   <= sspc_pkg::rst_divider;
      vco_pump  <= sspc_pkg::rst_vco_pump;
      override  <= sspc_pkg::rst_override;
      sep_ticks <= sspc_pkg::rst_sep_ticks;
    end else if (do_write && w_strb[0]) begin
      if (aw_addr == sspc_pkg::addr_div_high) begin
        divider[11:4] <= w_data[7:0];
      end else if (aw_addr == sspc_pkg::addr_div_low) begin
        divider[3:0] <= w_data[7:4];
      end else if (aw_addr == sspc_pkg::addr_vco_pump) begin
        vco_pump <= w_data[7:0];
      end else if (aw_addr == sspc_pkg::addr_override) begin
        override <= w_data[7:0];
      end else if (aw_addr == sspc_pkg::addr_sep_ticks) begin
        sep_ticks <= w_data[7:0];
      end
    end
  end

  // AXI4-Lite read
  // Unmapped offsets read as zero with an error response
  logic [7:0] status;
  assign status = {hs_active, 1'b0, hs_pol, vs_active, 1'b0, vs_pol, gs_active, 1'b0};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= resp_okay;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= resp_okay;
        if (s_axi_araddr == sspc_pkg::addr_div_high) begin
          s_axi_rdata <= {24'h00_0000, divider[11:4]};
        end else if (s_axi_araddr == sspc_pkg::addr_div_low) begin
          s_axi_rdata <= {24'h00_0000, divider[3:0], 4'h0};
        end else if (s_axi_araddr == sspc_pkg::addr_vco_pump) begin
          s_axi_rdata <= {24'h00_0000, vco_pump};
        end else if (s_axi_araddr == sspc_pkg::addr_override) begin
          s_axi_rdata <= {24'h00_0000, override};
        end else if (s_axi_araddr == sspc_pkg::addr_status) begin
          s_axi_rdata <= {24'h00_0000, status};
        end else if (s_axi_araddr == sspc_pkg::addr_sep_ticks) begin
          s_axi_rdata <= {24'h00_0000, sep_ticks};
        end else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= resp_slverr;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// file: test/sspc_video_src.sv
// Video source model: separate and composite-on-green sync generator
`timescale 1ns/1ps
module sspc_video_src (
  input  wire logic aclk,
  input  wire logic hs_on,
  input  wire logic hs_neg,
  input  wire logic vs_on,
  input  wire logic g_on,
  output logic      hsync_in,
  output logic      vsync_in,
  output logic      green_sync_in
);
  logic [6:0] hcnt = 7'h00;
  logic [4:0] line = 5'h00;
  logic       hp;
  logic       vp;
  // 80-cycle lines, 4-cycle line pulse, 20-line frame, 4-line frame pulse
  // Lines long enough for the default separator setting to hold the level between pulses
  assign hp = hcnt < 7'h04;
  assign vp = line < 5'h04;
  always_ff @(posedge aclk) begin
    hcnt <= (hcnt == 7'h4f) ? 7'h00 : hcnt + 7'h01;
    if (hcnt == 7'h4f) begin
      line <= (line == 5'h13) ? 5'h00 : line + 5'h01;
    end
  end
  // Idle lines rest at their inactive level, as an unplugged driver would leave them
  always_ff @(posedge aclk) begin
    hsync_in      <= hs_on ? hp ^ hs_neg : hs_neg;
    vsync_in      <= vs_on & vp;
    green_sync_in <= g_on ? ~(hp | vp) : 1'b1;
  end
endmodule

// file: test/sspc_properties.sv
// Checker: bus answers and register-driven outputs
`timescale 1ns/1ps
module sspc_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [9:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [9:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [11:0] pll_divide_by,
  input wire logic [1:0]  vco_range,
  input wire logic [2:0]  pump_current
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [9:0] aw_q;
  logic [9:0] ar_q;
  logic [7:0] w_q;
  logic       w_en;
  logic       wr_done;
  always_ff @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready) begin
      aw_q <= s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_q  <= s_axi_wdata[7:0];
      w_en <= s_axi_wstrb[0];
    end
    if (s_axi_arvalid && s_axi_arready) begin
      ar_q <= s_axi_araddr;
    end
  end
  assign wr_done = s_axi_bvalid && s_axi_bready && w_en;
  function automatic logic mapped(input logic [9:0] a);
    return a inside {sspc_pkg::addr_div_high, sspc_pkg::addr_div_low, sspc_pkg::addr_vco_pump,
                     sspc_pkg::addr_override, sspc_pkg::addr_status, sspc_pkg::addr_sep_ticks};
  endfunction
  chk_div_reset: assert property ($rose(aresetn) |-> pll_divide_by == sspc_pkg::rst_divider)
    else $error("divider not at reset value");
  chk_div_high: assert property (wr_done && aw_q == sspc_pkg::addr_div_high
    |=> pll_divide_by[11:4] == w_q) else $error("divider high bits not written");
  chk_div_low: assert property (wr_done && aw_q == sspc_pkg::addr_div_low
    |=> pll_divide_by[3:0] == w_q[7:4]) else $error("divider low bits not written");
  chk_vco_pump: assert property (wr_done && aw_q == sspc_pkg::addr_vco_pump
    |=> {vco_range, pump_current} == w_q[7:3]) else $error("vco or pump field wrong");
  chk_write_resp: assert property (s_axi_bvalid |-> s_axi_bresp == (mapped(aw_q) ? 2'h0 : 2'h2))
    else $error("write response code wrong");
  chk_read_resp: assert property (s_axi_rvalid |-> s_axi_rresp == (mapped(ar_q) ? 2'h0 : 2'h2))
    else $error("read response code wrong");
  chk_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_status_bits: assert property (s_axi_rvalid && ar_q == sspc_pkg::addr_status
    |-> (s_axi_rdata & 32'hffff_ff49) == 32'h0000_0000) else $error("unused status bit set");
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  cover property (s_axi_rvalid && !s_axi_rready);
  cover property (wr_done && aw_q == sspc_pkg::addr_vco_pump);
endmodule
bind sspc_sync_pll_ctrl sspc_checker chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .pll_divide_by, .vco_range, .pump_current);

// file: test/sync_select_pll_control_tb.sv
// Testbench: register bus and sync selection scenarios
`timescale 1ns/1ps
module sync_select_pll_control_tb;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [9:0]  s_axi_awaddr = 10'h000;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic [9:0]  s_axi_araddr = 10'h000;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, rsp, rdv;
  logic        hsync_in, vsync_in, green_sync_in, pll_ref_out, pll_ref_selector, vert_sync_out;
  logic        vert_source_selector, coast_out, sep_vsync_out;
  logic [11:0] pll_divide_by;
  logic [1:0]  vco_range;
  logic [2:0]  pump_current;
  logic [3:0]  q;
  logic        hs_on = 1'b0, hs_neg = 1'b1, vs_on = 1'b0, g_on = 1'b0;
  logic [11:0] div_set [2] = '{12'hfff, 12'h010};
  int          n_errors = 0, samples_checked = 0, cycles = 0, n_sep, n_vout, n_coast, n_ref;
  initial begin
    forever #50 aclk = ~aclk;
  end
  sspc_sync_pll_ctrl dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .hsync_in,
    .vsync_in, .green_sync_in, .pll_ref_out, .pll_ref_selector, .vert_sync_out, .vert_source_selector,
    .coast_out, .sep_vsync_out, .pll_divide_by, .vco_range, .pump_current);
  sspc_video_src src (.aclk, .hs_on, .hs_neg, .vs_on, .g_on, .hsync_in, .vsync_in, .green_sync_in);
  always @(posedge aclk) begin
    q <= {sep_vsync_out, vert_sync_out, coast_out, pll_ref_out};
    n_sep += int'(sep_vsync_out && !q[3]);
    n_vout += int'(vert_sync_out && !q[2]);
    n_coast += int'(coast_out && !q[1]);
    n_ref += int'(pll_ref_out === 1'b1);
    cycles++;
    if (cycles == 60000) begin
      n_errors++;
      wrap_up();
    end
  end
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // Response ready is raised in the cycle bvalid rises, so the write answer is taken at once and never held
  task automatic wr(input logic [9:0] a, input logic [7:0] d, input logic [3:0] s);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    fork
      begin
        do @(posedge aclk); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (s_axi_wready !== 1'b1);
        s_axi_wvalid <= 1'b0;
      end
    join
    @(posedge aclk);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    rsp = {30'h0000_0000, s_axi_bresp};
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rdv = s_axi_rdata;
    rsp = {30'h0000_0000, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask
  task automatic rc(input string n, input logic [9:0] a, input logic [31:0] e);
    rd(a);
    check(n, rdv, e);
  endtask
  task automatic sel(input logic [7:0] ov, input logic er, input logic ev);
    wr(sspc_pkg::addr_override, ov, 4'hf);
    repeat (4) @(posedge aclk);
    check("ref select", {31'h0000_0000, pll_ref_selector}, {31'h0000_0000, er});
    check("vert select", {31'h0000_0000, vert_source_selector}, {31'h0000_0000, ev});
  endtask
  task automatic frame();
    @(negedge aclk);
    {n_sep, n_vout, n_coast, n_ref} = '0;
    repeat (1600) @(posedge aclk);
    @(negedge aclk);
  endtask
  task automatic sep(input logic [7:0] ov, input logic [7:0] t, input int e);
    wr(sspc_pkg::addr_override, ov, 4'hf);
    wr(sspc_pkg::addr_sep_ticks, t, 4'hf);
    frame();
    frame();
    check("separator pulses", n_sep, e);
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check("divider port", {20'h0_0000, pll_divide_by}, 32'h0000_069d);
    rc("div high", sspc_pkg::addr_div_high, 32'h0000_0069);
    rc("div low", sspc_pkg::addr_div_low, 32'h0000_00d0);
    rc("vco pump", sspc_pkg::addr_vco_pump, 32'h0000_0000);
    rc("override", sspc_pkg::addr_override, 32'h0000_0000);
    rc("sep ticks", sspc_pkg::addr_sep_ticks, 32'h0000_0020);
    rc("status idle", sspc_pkg::addr_status, 32'h0000_0004);
    sel(8'h00, 1'b0, 1'b0);
    sel(8'h01, 1'b0, 1'b1);
    sel(8'h18, 1'b1, 1'b0);
    sel(8'h12, 1'b0, 1'b0);
    hs_on <= 1'b1;
    repeat (8) @(posedge aclk);
    frame();
    check("ref highs", n_ref, 80);
    rc("status neg", sspc_pkg::addr_status, 32'h0000_0084);
    sel(8'h08, 1'b0, 1'b0);
    rd(10'h3fc);
    check("unmapped rresp", rsp, 32'h0000_0002);
    check("unmapped rdata", rdv, 32'h0000_0000);
    wr(10'h3fc, 8'hff, 4'hf);
    check("unmapped bresp", rsp, 32'h0000_0002);
    wr(sspc_pkg::addr_status, 8'hff, 4'hf);
    check("status bresp", rsp, 32'h0000_0000);
    rc("status kept", sspc_pkg::addr_status, 32'h0000_0084);
    foreach (div_set[i]) begin
      wr(sspc_pkg::addr_div_high, div_set[i][11:4], 4'hf);
      wr(sspc_pkg::addr_div_low, {div_set[i][3:0], 4'h0}, 4'hf);
      @(negedge aclk);
      check("divider", {20'h0_0000, pll_divide_by}, {20'h0_0000, div_set[i]});
    end
    for (int i = 0; i < 32; i++) begin
      wr(sspc_pkg::addr_vco_pump, 8'(i << 3), 4'hf);
      @(negedge aclk);
      check("vco pump", {27'h000_0000, vco_range, pump_current}, 32'(i));
    end
    wr(sspc_pkg::addr_vco_pump, 8'h00, 4'h0);
    check("strobe off", {27'h000_0000, vco_range, pump_current}, 32'h0000_001f);
    hs_neg <= 1'b0;
    repeat (4000) @(posedge aclk);
    frame();
    check("ref highs", n_ref, 80);
    rc("status pos", sspc_pkg::addr_status, 32'h0000_00a4);
    g_on <= 1'b1;
    repeat (100) @(posedge aclk);
    rc("status green", sspc_pkg::addr_status, 32'h0000_00a6);
    sel(8'h00, 1'b0, 1'b1);
    sel(8'h08, 1'b1, 1'b1);
    sel(8'h02, 1'b0, 1'b0);
    sel(8'h10, 1'b0, 1'b1);
    sep(8'h04, 8'h20, 1);
    sep(8'h04, 8'hff, 0);
    sep(8'h24, 8'h00, 16);
    check("coast pulses", n_coast, 16);
    sep(8'h00, 8'h00, 20);
    @(posedge aclk);
    hs_on <= 1'b0;
    repeat (1200) @(posedge aclk);
    rd(sspc_pkg::addr_status);
    check("status no hs", rdv & 32'h0000_00ba, 32'h0000_0022);
    sel(8'h00, 1'b1, 1'b1);
    vs_on <= 1'b1;
    repeat (20000) @(posedge aclk);
    rc("status vs", sspc_pkg::addr_status, 32'h0000_0036);
    sel(8'h03, 1'b1, 1'b1);
    sel(8'h00, 1'b1, 1'b0);
    frame();
    check("vert pulses", n_vout, 1);
    check("coast pulses", n_coast, 1);
    wrap_up();
  end
endmodule
